// [verilog/lei_pkg.sv]
// Constants and types shared by the link error interrupt signal enable block
`default_nettype none
package lei_pkg;
	localparam logic [11:0] LEI_ENABLE_OFFSET = 12'h000;
	localparam logic [11:0] LEI_STATUS_OFFSET = 12'h004;
	localparam logic [11:0] LEI_PENDING_OFFSET = 12'h008;
	localparam logic [15:0] LEI_IMPL_MASK     = 16'h81bf;
	localparam logic [15:0] LEI_ENABLE_RESET  = 16'h0000;
	localparam int          LEI_BIT_ADMA      = 15;
	localparam int          LEI_BIT_EBSY      = 8;
	localparam int          LEI_BIT_UNREC     = 7;
	localparam int          LEI_BIT_TID       = 5;
	localparam int          LEI_BIT_FRAMING   = 4;
	localparam int          LEI_BIT_CRC       = 3;
	localparam int          LEI_BIT_RETRY     = 2;
	localparam int          LEI_BIT_RESPKT    = 1;
	localparam int          LEI_BIT_HEADER    = 0;
	localparam logic [1:0]  LEI_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0]  LEI_HSIZE_WORD    = 3'h2;
	typedef enum logic [1:0] {
		LEI_SEL_ENABLE  = 2'h0,
		LEI_SEL_STATUS  = 2'h1,
		LEI_SEL_PENDING = 2'h3,
		LEI_SEL_NONE    = 2'h2
	} lei_sel_t;
endpackage
`default_nettype wire

// [verilog/lei_reg_if.sv]
// Register write and read carrier between bus slave and enable core
`timescale 1ns/1ps
`default_nettype none
interface lei_reg_if;
	import lei_pkg::*;
	logic     wr_en;
	logic [15:0] wr_data;
	lei_sel_t sel;
	logic [31:0] rd_data;
	modport slave (output wr_en, output wr_data, output sel, input rd_data);
	modport core  (input wr_en, input wr_data, input sel, output rd_data);
endinterface
`default_nettype wire

// [verilog/lei_core.sv]
// Enable register, per-source gating and read mux
`timescale 1ns/1ps
`default_nettype none
module lei_core
	import lei_pkg::*;
#(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// Register access
	lei_reg_if.core               regs,
	// Status in, enable and pending out
	input  wire logic [WIDTH-1:0] status,
	output logic      [WIDTH-1:0] enable,
	output logic      [WIDTH-1:0] pending
);
	// Storage only for implemented positions; reserved ones stay constant zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable <= LEI_ENABLE_RESET;
		end else if (regs.wr_en) begin
			enable <= regs.wr_data & LEI_IMPL_MASK;
		end
	end

	// One gate per source; reserved columns are masked off as well
	for (genvar i = 0; i < WIDTH; i++) begin : g_gate
		assign pending[i] = status[i] & enable[i] & LEI_IMPL_MASK[i];
	end

	always_comb begin
		unique case (regs.sel)
			LEI_SEL_ENABLE:  regs.rd_data = {16'h0000, enable};
			LEI_SEL_STATUS:  regs.rd_data = {16'h0000, status & LEI_IMPL_MASK};
			LEI_SEL_PENDING: regs.rd_data = {16'h0000, pending};
			LEI_SEL_NONE:    regs.rd_data = 32'h0000_0000;
		endcase
	end
endmodule // lei_core
`default_nettype wire

// [verilog/lei_top.sv]
// AHB-Lite slave and interrupt request of the link error signal enable block
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module lei_top
	import lei_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Latched link error status from the status logic
	input  wire logic [15:0] err_status,
	// Interrupt request to the system
	output logic             irq
);
	lei_reg_if regs ();
	logic [15:0] enable;
	logic [15:0] pending;
	logic        wr_pend;
	logic        rd_pend;
	lei_sel_t    sel_q;
	lei_sel_t    next_sel;

	always_comb begin
		unique case (haddr)
			LEI_ENABLE_OFFSET:  next_sel = LEI_SEL_ENABLE;
			LEI_STATUS_OFFSET:  next_sel = LEI_SEL_STATUS;
			LEI_PENDING_OFFSET: next_sel = LEI_SEL_PENDING;
			default:            next_sel = LEI_SEL_NONE;
		endcase
	end

	// Address phase capture; one wait-free data phase follows
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			sel_q   <= LEI_SEL_NONE;
		end else if (hready) begin
			wr_pend <= hsel && htrans == LEI_HTRANS_NONSEQ && hwrite;
			rd_pend <= hsel && htrans == LEI_HTRANS_NONSEQ && !hwrite;
			sel_q   <= next_sel;
		end else begin
			wr_pend <= 1'b0;
		end
	end

	assign regs.wr_en   = wr_pend && sel_q == LEI_SEL_ENABLE;
	assign regs.wr_data = hwdata[15:0];
	// Select decoded from the address phase, so read data is registered without a wait state
	assign regs.sel     = next_sel;

	lei_core #(.WIDTH(16)) u_core (
		.hclk    (hclk),
		.hresetn (hresetn),
		.regs    (regs),
		.status  (err_status),
		.enable  (enable),
		.pending (pending)
	);

	// Slave answers OKAY always; writes and reads finish without wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Read data launched in the address phase so it stands through the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans == LEI_HTRANS_NONSEQ && !hwrite) begin
			hrdata <= regs.rd_data;
		end
	end

	// Registered OR keeps the output glitch free, at one cycle of latency
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |pending;
		end
	end

	a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
		##1 irq == |($past(err_status) & $past(enable)))
		else $error("irq does not follow enabled status");
	a_adma_pass: assert property (@(posedge hclk) disable iff (!hresetn)
		enable[15] && err_status[15] |=> irq)
		else $error("advanced_dma_error not signalled");
	a_ebsy_pass: assert property (@(posedge hclk) disable iff (!hresetn)
		enable[8] && err_status[8] |=> irq)
		else $error("busy error not signalled");
	a_unrec_pass: assert property (@(posedge hclk) disable iff (!hresetn)
		enable[7] && err_status[7] |=> irq)
		else $error("unrecoverable error not signalled");
	a_tid_pass: assert property (@(posedge hclk) disable iff (!hresetn)
		enable[5] && err_status[5] |=> irq)
		else $error("transaction_id_error not signalled");
	a_framing_pass: assert property (@(posedge hclk) disable iff (!hresetn)
		enable[4] && err_status[4] |=> irq)
		else $error("framing error not signalled");
	a_crc_pass: assert property (@(posedge hclk) disable iff (!hresetn)
		enable[3] && err_status[3] |=> irq)
		else $error("crc error not signalled");
	a_retry_pass: assert property (@(posedge hclk) disable iff (!hresetn)
		enable[2] && err_status[2] |=> irq)
		else $error("retry error not signalled");
	a_respkt_pass: assert property (@(posedge hclk) disable iff (!hresetn)
		enable[1] && err_status[1] |=> irq)
		else $error("response packet error not signalled");
	a_header_pass: assert property (@(posedge hclk) disable iff (!hresetn)
		enable[0] && err_status[0] |=> irq)
		else $error("header error not signalled");
	a_mask_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
		enable == 16'h0000 |=> !irq)
		else $error("masked source raised irq");
	a_rsvd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		(enable & ~LEI_IMPL_MASK) == 16'h0000)
		else $error("reserved enable bit set");
	a_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
		regs.wr_en |=> enable == ($past(hwdata[15:0]) & LEI_IMPL_MASK))
		else $error("enable write lost");
	a_enable_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		!regs.wr_en |=> $stable(enable))
		else $error("enable changed without a write");
	a_irq_only_enabled: assert property (@(posedge hclk) disable iff (!hresetn)
		(err_status & enable) == 16'h0000 |=> !irq)
		else $error("irq raised with no enabled status");
	a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
		hreadyout && !hresp)
		else $error("slave not ready or not okay");
	// Read data must not move between read address phases
	a_rdata_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		!(hready && hsel && htrans == LEI_HTRANS_NONSEQ && !hwrite) |=> $stable(hrdata))
		else $error("read data moved outside a read");
	a_read_enable: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_pend && sel_q == LEI_SEL_ENABLE |-> hrdata == {16'h0000, $past(enable)})
		else $error("enable read data wrong");
	a_read_status: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_pend && sel_q == LEI_SEL_STATUS |-> hrdata == {16'h0000, $past(err_status) & LEI_IMPL_MASK})
		else $error("status read data wrong");
	a_read_pending: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_pend && sel_q == LEI_SEL_PENDING |-> hrdata == {16'h0000, $past(err_status) & $past(enable)})
		else $error("pending read data wrong");
	a_read_unmapped: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_pend && sel_q == LEI_SEL_NONE |-> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule // lei_top
`default_nettype wire

// [sim/lei_err_src.sv]
// Model of the latched link error status logic
`timescale 1ns/1ps
`default_nettype none
module lei_err_src (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Error events and clears
	input  wire logic [15:0] set_bits,
	input  wire logic [15:0] clr_bits,
	// Latched status
	output logic      [15:0] err_status
);
	// Sticky bits; only a clear drops them, never an enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_status <= 16'h0000;
		end else begin
			err_status <= (err_status & ~clr_bits) | set_bits;
		end
	end
endmodule // lei_err_src
`default_nettype wire

// [sim/link_error_irq_signal_enable_tb.sv]
// Self-checking bench of the link error signal enable block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module link_error_irq_signal_enable_tb;
	import lei_pkg::*;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq;
	logic [11:0] haddr = 12'h000;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h0;
	logic [31:0] hwdata = 32'h0, hrdata, rd;
	logic [15:0] err_status, set_bits = 16'h0, clr_bits = 16'h0, en, sv;
	int          mismatches = 0, num_checks = 0, seed = 67;
	int          bits[9] = '{15, 8, 7, 5, 4, 3, 2, 1, 0};
	always #12.5 hclk = ~hclk;
	assign hready = hreadyout;
	lei_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .err_status(err_status), .irq(irq));
	lei_err_src src (.hclk(hclk), .hresetn(hresetn), .set_bits(set_bits), .clr_bits(clr_bits),
		.err_status(err_status));
	function automatic logic ex_irq(logic [15:0] e, logic [15:0] s);
		return |(e & s & 16'h81bf);
	endfunction
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Bounded wait: a stuck slave ends the run
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (hready !== 1'b1) begin
			mismatches++;
			summarize();
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= LEI_HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= LEI_HSIZE_WORD;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
		`CHK(hresp, 1'b0)
	endtask
	// Load status, let irq settle, check at the falling edge
	task automatic st_chk(input logic [15:0] v, input logic e);
		@(posedge hclk);
		set_bits <= v;
		clr_bits <= 16'hffff;
		@(posedge hclk);
		set_bits <= 16'h0;
		clr_bits <= 16'h0;
		repeat (2) @(posedge hclk);
		@(negedge hclk);
		`CHK(irq, e)
	endtask
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(1'b0, LEI_ENABLE_OFFSET, 32'h0);
		`CHK(rd, 32'h0)
		xfer(1'b1, LEI_ENABLE_OFFSET, 32'hffffffff);
		xfer(1'b0, LEI_ENABLE_OFFSET, 32'h0);
		`CHK(rd, 32'h000081bf)
		st_chk(16'h7e40, 1'b0);
		$display("test reserved done");
		for (int i = 0; i < 9; i++) begin
			xfer(1'b1, LEI_ENABLE_OFFSET, 32'h1 << bits[i]);
			st_chk(16'hffff, 1'b1);
			st_chk(~(16'h1 << bits[i]), 1'b0);
		end
		$display("test per source done");
		for (int k = 0; k < 24; k++) begin
			en = 16'($random(seed));
			sv = 16'($random(seed));
			if (k == 0) sv = 16'h0;
			xfer(1'b1, LEI_ENABLE_OFFSET, {16'hffff, en});
			st_chk(sv, ex_irq(en, sv));
			xfer(1'b0, LEI_PENDING_OFFSET, 32'h0);
			`CHK(rd, {16'h0, sv & en & 16'h81bf})
			xfer(1'b0, LEI_STATUS_OFFSET, 32'h0);
			`CHK(rd, {16'h0, sv & 16'h81bf})
		end
		xfer(1'b0, 12'h010, 32'h0);
		`CHK(rd, 32'h0)
		$display("test random done");
		// Mid-run reset must drop irq and clear the enables
		xfer(1'b1, LEI_ENABLE_OFFSET, 32'h0000ffff);
		st_chk(16'hffff, 1'b1);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		@(negedge hclk);
		`CHK(irq, 1'b0)
		@(posedge hclk);
		hresetn <= 1'b1;
		xfer(1'b0, LEI_ENABLE_OFFSET, 32'h0);
		`CHK(rd, 32'h0)
		st_chk(16'hffff, 1'b0);
		$display("test reset done");
		summarize();
	end
endmodule // link_error_irq_signal_enable_tb
`default_nettype wire
